//--- verilog/acs_pkg.sv
// axis current and status block: shared constants, register map and bus carrier types
// assumes a single 100 MHz clock domain and a plain strobe register port
package acs_pkg;

	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_HZ           = 100_000_000;
	localparam int unsigned FREEWHEEL_UNIT_MS = 10;
	localparam int unsigned FREEWHEEL_TICK_CYC = CLK_HZ / 1000 * FREEWHEEL_UNIT_MS;
	localparam int unsigned STANDSTILL_LOG2  = 20;
	localparam int unsigned STANDSTILL_CYC   = 1 << STANDSTILL_LOG2;

	// ==========================================================
	// register bus
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_BOOST_CURRENT   = 12'h0C8;
	localparam logic [ADDR_W-1:0] IDX_FREEWHEEL_DELAY = 12'h0CC;
	localparam logic [ADDR_W-1:0] IDX_ACTUAL_LOAD     = 12'h0CE;
	localparam logic [ADDR_W-1:0] IDX_EXT_ERR_FLAGS   = 12'h0CF;
	localparam logic [ADDR_W-1:0] IDX_DRV_ERR_FLAGS   = 12'h0D0;
	localparam logic [ADDR_W-1:0] IDX_ENCODER_COUNT   = 12'h0D1;
	localparam logic [ADDR_W-1:0] IDX_ENCODER_SCALER  = 12'h0D2;
	localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS      = 12'h0E0;
	localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR       = 12'h0E1;
	localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE      = 12'h0E2;
	localparam int unsigned IDX_SHIFT = 2;

	// ==========================================================
	// field widths and positions
	localparam int unsigned CUR_W     = 8;
	localparam int unsigned DELAY_W   = 16;
	localparam int unsigned LOAD_W    = 10;
	localparam int unsigned EXT_W     = 2;
	localparam int unsigned DRV_W     = 8;
	localparam int unsigned DRV_PIN_W = 7;
	localparam int unsigned FRAC_W    = 16;
	localparam int unsigned IRQ_W     = 4;

	localparam int unsigned EXT_STALL_BIT = 0;
	localparam int unsigned EXT_DEV_BIT   = 1;
	localparam int unsigned DRV_STILL_BIT = 7;

	localparam int unsigned IRQ_STALL_BIT = 0;
	localparam int unsigned IRQ_DEV_BIT   = 1;
	localparam int unsigned IRQ_DRV_BIT   = 2;
	localparam int unsigned IRQ_CUT_BIT   = 3;

	// ==========================================================
	// reset values
	localparam logic [CUR_W-1:0]   BOOST_RST   = 8'h00;
	localparam logic [DELAY_W-1:0] DELAY_RST   = 16'h0000;
	localparam logic [DATA_W-1:0]  SCALER_RST  = 32'h0001_0000;
	localparam logic [DATA_W-1:0]  ZERO_WORD   = 32'h0000_0000;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} acs_bus_req_t;

	// driver status pins, bit order matches the driver error byte
	typedef struct packed {
		logic olb;
		logic ola;
		logic s2gb;
		logic s2ga;
		logic otpw;
		logic ot;
		logic stall_thr;
	} acs_drv_pins_t;

	typedef enum logic [1:0] {
		QUAD_S0,
		QUAD_S1,
		QUAD_S2,
		QUAD_S3
	} acs_quad_t;

endpackage

//--- verilog/acs_sync.sv
// acs_sync: two-stage synchroniser for a bundle of asynchronous levels
// assumes destination clock clk; first stage is read only by the second
module acs_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// ==========================================================
	// per-bit stages
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_r[i] <= 1'b0;
					q[i]      <= 1'b0;
				end else if (clk_en) begin
					meta_r[i] <= d[i];
					q[i]      <= meta_r[i];
				end
			end
		end
	endgenerate
endmodule

//--- verilog/acs_axis_status.sv
// acs_axis_status: boost current selection, freewheel power cut, load and error
// read-outs, encoder counter with prescaler, and an interrupt summary
// assumes motion-profile signals come from logic on clk; driver status, step and
// encoder lines are pins and are synchronised here
//
// Contract
// RL1: while accelerating or decelerating the coil current is the boost setting, or run current if boost is zero.
// RL2: boost current is an 8-bit value with the same scaling as run current.
// RL3: after velocity reaches zero, 10 ms units are counted and motor power is cut when the 16-bit delay expires.
// RL4: a freewheel delay of zero never cuts power, and zero is the reset value.
// RL5: a read-only 10-bit actual load value equal to the stall detection input is exposed.
// RL6: extended error flags are two bits, 1 for stall and 2 for deviation, both may be set.
// RL7: extended error flags clear when read or when a motion command executes.
// RL8: driver error bit 0 shows stall threshold reached and bit 1 overtemperature shutdown.
// RL9: driver error bit 2 shows overtemperature pre-warning while exceeded.
// RL10: driver error bits 3 and 4 show short to ground on coil A and coil B.
// RL11: driver error bits 5 and 6 show open load on coil A and coil B.
// RL12: driver error bit 7 shows standstill when no step pulse came in the last 2^20 clocks.
// RL13: encoder steps pass through a configurable prescaler before accumulation.
// RL14: the encoder counter is signed 32-bit, readable and overwritable by the host.
//
// Implementation choice: the plain strobed port.
module acs_axis_status #(
	parameter int unsigned TICK_CYC  = acs_pkg::FREEWHEEL_TICK_CYC,
	parameter int unsigned STILL_CYC = acs_pkg::STANDSTILL_CYC
) (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic                     clk_en,
	input  wire acs_pkg::acs_bus_req_t    bus_req,
	output logic [acs_pkg::DATA_W-1:0]    bus_rdata,
	input  wire logic [acs_pkg::CUR_W-1:0] run_current,
	input  wire logic                     ramp_phase,
	input  wire logic                     velocity_zero,
	input  wire logic                     motion_cmd,
	input  wire logic [acs_pkg::LOAD_W-1:0] load_value,
	input  wire logic                     stall_event,
	input  wire logic                     deviation_event,
	input  wire acs_pkg::acs_drv_pins_t   drv_pins,
	input  wire logic                     step_pin,
	input  wire logic                     enc_a_pin,
	input  wire logic                     enc_b_pin,
	output logic [acs_pkg::CUR_W-1:0]     coil_current,
	output logic                          motor_power_en,
	output logic                          irq
);
	import acs_pkg::*;

	localparam int unsigned TICK_W  = $clog2(TICK_CYC + 1);
	localparam int unsigned STILL_W = $clog2(STILL_CYC + 1);
	localparam logic [TICK_W-1:0]  TICK_LAST  = TICK_W'(TICK_CYC - 1);
	localparam logic [STILL_W-1:0] STILL_LAST = STILL_W'(STILL_CYC - 1);
	localparam int unsigned SYNC_W = DRV_PIN_W + 3;

	// ==========================================================
	// reset release
	logic rst_meta_r;
	logic rst_n;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// ==========================================================
	// pin synchronisation
	logic [SYNC_W-1:0] pins_q;
	acs_drv_pins_t     drv_s;
	logic              step_s;
	logic              enc_a_s;
	logic              enc_b_s;

	acs_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.clk_en(clk_en),
		.d     ({drv_pins, step_pin, enc_a_pin, enc_b_pin}),
		.q     (pins_q)
	);

	assign drv_s   = pins_q[SYNC_W-1:3];
	assign step_s  = pins_q[2];
	assign enc_a_s = pins_q[1];
	assign enc_b_s = pins_q[0];

	// ==========================================================
	// register decode
	logic [ADDR_W-1:0] idx;
	logic              idx_ok;
	logic              wr_boost;
	logic              wr_delay;
	logic              wr_count;
	logic              wr_scaler;
	logic              wr_irq_clr;
	logic              wr_irq_en;
	logic              rd_ext;

	// byte address must be word aligned
	assign idx_ok     = (bus_req.addr[IDX_SHIFT-1:0] == '0);
	assign idx        = ADDR_W'(bus_req.addr >> IDX_SHIFT);
	assign wr_boost   = bus_req.wr && idx_ok && (idx == IDX_BOOST_CURRENT);
	assign wr_delay   = bus_req.wr && idx_ok && (idx == IDX_FREEWHEEL_DELAY);
	assign wr_count   = bus_req.wr && idx_ok && (idx == IDX_ENCODER_COUNT);
	assign wr_scaler  = bus_req.wr && idx_ok && (idx == IDX_ENCODER_SCALER);
	assign wr_irq_clr = bus_req.wr && idx_ok && (idx == IDX_IRQ_CLEAR);
	assign wr_irq_en  = bus_req.wr && idx_ok && (idx == IDX_IRQ_ENABLE);
	assign rd_ext     = bus_req.rd && idx_ok && (idx == IDX_EXT_ERR_FLAGS);

	// ==========================================================
	// configuration registers
	logic [CUR_W-1:0]   boost_current_r;
	logic [DELAY_W-1:0] freewheel_delay_r;
	logic [DATA_W-1:0]  encoder_scaler_r;
	logic [IRQ_W-1:0]   irq_enable_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			boost_current_r   <= BOOST_RST;
			freewheel_delay_r <= DELAY_RST; // RL4
			encoder_scaler_r  <= SCALER_RST;
			irq_enable_r      <= '0;
		end else if (clk_en) begin
			if (wr_boost)
				boost_current_r <= bus_req.wdata[CUR_W-1:0]; // RL2
			if (wr_delay)
				freewheel_delay_r <= bus_req.wdata[DELAY_W-1:0];
			if (wr_scaler)
				encoder_scaler_r <= bus_req.wdata;
			if (wr_irq_en)
				irq_enable_r <= bus_req.wdata[IRQ_W-1:0];
		end
	end

	// ==========================================================
	// current selection
	logic [CUR_W-1:0] coil_current_nxt;

	assign coil_current_nxt = (ramp_phase && (boost_current_r != '0)) ? boost_current_r
		: run_current; // RL1

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			coil_current <= '0;
		else if (clk_en)
			coil_current <= coil_current_nxt; // RL1
	end

	// ==========================================================
	// freewheel timer
	// the unit counter restarts with each standstill so the first unit is a full 10 ms
	logic [TICK_W-1:0]  tick_cnt_r;
	logic [DELAY_W-1:0] unit_cnt_r;
	logic               cut_r;
	logic               cut_evt;

	assign cut_evt = velocity_zero && !cut_r && (freewheel_delay_r != '0)
		&& (unit_cnt_r >= freewheel_delay_r);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_r <= '0;
			unit_cnt_r <= '0;
		end else if (clk_en) begin
			if (!velocity_zero) begin
				tick_cnt_r <= '0;
				unit_cnt_r <= '0;
			end else if (tick_cnt_r == TICK_LAST) begin
				tick_cnt_r <= '0;
				if (unit_cnt_r != '1)
					unit_cnt_r <= unit_cnt_r + 1'b1; // RL3
			end else begin
				tick_cnt_r <= tick_cnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cut_r <= 1'b0;
		else if (clk_en) begin
			if (!velocity_zero || (freewheel_delay_r == '0))
				cut_r <= 1'b0; // RL4
			else if (cut_evt)
				cut_r <= 1'b1; // RL3
		end
	end

	assign motor_power_en = !cut_r;

	// ==========================================================
	// extended error flags
	logic [EXT_W-1:0] ext_flags_r;
	logic [EXT_W-1:0] ext_set;

	assign ext_set = {deviation_event, stall_event}; // RL6

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ext_flags_r <= '0;
		else if (clk_en) begin
			// a new event in the clearing cycle survives the clear
			if (rd_ext || motion_cmd)
				ext_flags_r <= ext_set; // RL7
			else
				ext_flags_r <= ext_flags_r | ext_set; // RL6
		end
	end

	// ==========================================================
	// standstill detection
	logic               step_d_r;
	logic               step_edge;
	logic [STILL_W-1:0] still_cnt_r;
	logic               still_r;

	assign step_edge = step_s && !step_d_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_d_r    <= 1'b0;
			still_cnt_r <= '0;
			still_r     <= 1'b0;
		end else if (clk_en) begin
			step_d_r <= step_s;
			if (step_edge) begin
				still_cnt_r <= '0;
				still_r     <= 1'b0;
			end else if (still_cnt_r == STILL_LAST) begin
				still_r <= 1'b1; // RL12
			end else begin
				still_cnt_r <= still_cnt_r + 1'b1;
			end
		end
	end

	// ==========================================================
	// driver error byte
	logic [DRV_W-1:0] drv_flags_r;
	logic [DRV_W-1:0] drv_flags_nxt;

	// bits 0..6 follow the driver status lines, bit 7 the standstill monitor
	assign drv_flags_nxt = {still_r, drv_s}; // RL8 RL9 RL10 RL11 RL12

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			drv_flags_r <= '0;
		else if (clk_en)
			drv_flags_r <= drv_flags_nxt;
	end

	// ==========================================================
	// encoder decode
	acs_quad_t quad_r;
	acs_quad_t quad_nxt;
	logic      enc_up;
	logic      enc_dn;

	always_comb begin
		unique case ({enc_a_s, enc_b_s})
			2'b00: quad_nxt = QUAD_S0;
			2'b10: quad_nxt = QUAD_S1;
			2'b11: quad_nxt = QUAD_S2;
			2'b01: quad_nxt = QUAD_S3;
		endcase
	end

	// states step by one per edge; a two-state jump is a missed edge and is dropped
	assign enc_up = (2'(quad_nxt) == 2'(quad_r) + 2'h1);
	assign enc_dn = (2'(quad_nxt) == 2'(quad_r) - 2'h1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			quad_r <= QUAD_S0;
		else if (clk_en)
			quad_r <= quad_nxt;
	end

	// ==========================================================
	// encoder prescaler and counter
	// scaler is 16.16 fixed point: counts added per encoder edge
	logic [FRAC_W-1:0]  frac_r;
	logic [FRAC_W:0]    frac_sum;
	logic [DATA_W-1:0]  step_amt;
	logic signed [DATA_W-1:0] encoder_count_r;

	assign frac_sum = {1'b0, frac_r} + {1'b0, encoder_scaler_r[FRAC_W-1:0]};
	assign step_amt = DATA_W'(encoder_scaler_r[DATA_W-1:FRAC_W])
		+ DATA_W'(frac_sum[FRAC_W]); // RL13

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frac_r          <= '0;
			encoder_count_r <= '0;
		end else if (clk_en) begin
			if (wr_count) begin
				encoder_count_r <= signed'(bus_req.wdata); // RL14
				frac_r          <= '0;
			end else if (enc_up || enc_dn) begin
				frac_r          <= frac_sum[FRAC_W-1:0];
				encoder_count_r <= enc_up ? encoder_count_r + signed'(step_amt)
					: encoder_count_r - signed'(step_amt); // RL13
			end
		end
	end

	// ==========================================================
	// interrupts
	logic [IRQ_W-1:0] irq_status_r;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic             drv_rise;

	assign drv_rise = |(drv_flags_nxt[DRV_PIN_W-1:0] & ~drv_flags_r[DRV_PIN_W-1:0]);
	// top bit down: cut, driver rise, deviation, stall
	assign irq_set  = {cut_evt, drv_rise, deviation_event, stall_event};
	assign irq_clr  = wr_irq_clr ? bus_req.wdata[IRQ_W-1:0] : '0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq_status_r <= '0;
		else if (clk_en)
			irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq <= 1'b0;
		else if (clk_en)
			irq <= |(irq_status_r & irq_enable_r);
	end

	// ==========================================================
	// read data
	logic [DATA_W-1:0] rdata_nxt;

	always_comb begin
		rdata_nxt = ZERO_WORD;
		if (idx_ok) begin
			unique case (idx)
				IDX_BOOST_CURRENT:   rdata_nxt = DATA_W'(boost_current_r);
				IDX_FREEWHEEL_DELAY: rdata_nxt = DATA_W'(freewheel_delay_r);
				IDX_ACTUAL_LOAD:     rdata_nxt = DATA_W'(load_value); // RL5
				IDX_EXT_ERR_FLAGS:   rdata_nxt = DATA_W'(ext_flags_r);
				IDX_DRV_ERR_FLAGS:   rdata_nxt = DATA_W'(drv_flags_r);
				IDX_ENCODER_COUNT:   rdata_nxt = DATA_W'(encoder_count_r); // RL14
				IDX_ENCODER_SCALER:  rdata_nxt = encoder_scaler_r;
				IDX_IRQ_STATUS:      rdata_nxt = DATA_W'(irq_status_r);
				IDX_IRQ_ENABLE:      rdata_nxt = DATA_W'(irq_enable_r);
				default:             rdata_nxt = ZERO_WORD;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			bus_rdata <= ZERO_WORD;
		else if (clk_en && bus_req.rd)
			bus_rdata <= rdata_nxt;
	end
endmodule

//--- tb/acs_axis_status_sva.sv
// acs_axis_status_sva: port-level checks of the axis status block
// assumes one clock domain; bound to every acs_axis_status instance
module acs_axis_status_sva
	import acs_pkg::*;
#(
	parameter int unsigned TICK_CYC = acs_pkg::FREEWHEEL_TICK_CYC
) (
	input wire logic                       clk,
	input wire logic                       nrst,
	input wire logic                       clk_en,
	input wire acs_pkg::acs_bus_req_t      bus_req,
	input wire logic [acs_pkg::DATA_W-1:0] bus_rdata,
	input wire logic [acs_pkg::CUR_W-1:0]  run_current,
	input wire logic                       ramp_phase,
	input wire logic                       velocity_zero,
	input wire logic [acs_pkg::LOAD_W-1:0] load_value,
	input wire logic                       stall_event,
	input wire logic                       deviation_event,
	input wire acs_pkg::acs_drv_pins_t     drv_pins,
	input wire logic [acs_pkg::CUR_W-1:0]  coil_current,
	input wire logic                       motor_power_en,
	input wire logic                       irq
);
	// ==========
	// shadows of writable settings, rebuilt from bus traffic
	logic [1:0]  live_r;
	logic [7:0]  boost_r;
	logic [15:0] delay_r;
	logic [3:0]  en_r;
	logic [31:0] zcnt_r;
	logic        wr_ok;
	logic        ext_rd;
	logic [7:0]  sel;
	assign wr_ok = bus_req.wr && clk_en;
	assign ext_rd = bus_req.rd && clk_en && bus_req.addr == 12'h33C;
	assign sel = (ramp_phase && boost_r != 8'h00) ? boost_r : run_current;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			live_r <= 2'h0;
			boost_r <= 8'h00;
			delay_r <= 16'h0000;
			en_r <= 4'h0;
			zcnt_r <= 32'h0;
		end else begin
			// internal reset copy lags two edges behind nrst
			if (live_r != 2'h3)
				live_r <= live_r + 2'h1;
			if (wr_ok && bus_req.addr == 12'h320)
				boost_r <= bus_req.wdata[7:0];
			if (wr_ok && bus_req.addr == 12'h330)
				delay_r <= bus_req.wdata[15:0];
			if (wr_ok && bus_req.addr == 12'h388)
				en_r <= bus_req.wdata[3:0];
			if (clk_en)
				zcnt_r <= velocity_zero ? zcnt_r + 32'h1 : 32'h0;
		end
	end

	// ==========
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_ext_twice;
		(ext_rd && !stall_event && !deviation_event) ##1 ext_rd;
	endsequence

	a_coil_select: assert property (live_r == 2'h3 && $past(clk_en) |->
		coil_current == $past(sel)) else $error("coil current wrong");
	a_boost_read: assert property (bus_req.rd && bus_req.addr == 12'h320 |=>
		bus_rdata == {24'h0, $past(boost_r)}) else $error("boost readback wrong");
	a_cut_early: assert property ($fell(motor_power_en) |->
		zcnt_r >= delay_r * TICK_CYC) else $error("power cut too early");
	a_cut_late: assert property (delay_r != 16'h0 && zcnt_r == delay_r * TICK_CYC + 4 |->
		!motor_power_en) else $error("power cut missing");
	a_power_moving: assert property (!velocity_zero [*2] |-> motor_power_en)
		else $error("power cut while moving");
	a_power_kept: assert property (delay_r == 16'h0 && $past(delay_r) == 16'h0 |->
		motor_power_en) else $error("power cut with zero delay");
	a_load_read: assert property (bus_req.rd && bus_req.addr == 12'h338 |=>
		bus_rdata == {22'h0, $past(load_value)}) else $error("load readback wrong");
	a_ext_width: assert property (ext_rd |=> bus_rdata[31:2] == 30'h0)
		else $error("extended flags too wide");
	a_ext_clear: assert property (s_ext_twice |=> bus_rdata == 32'h0)
		else $error("extended flags not cleared by read");
	a_drv_read: assert property (bus_req.rd && bus_req.addr == 12'h340 &&
		drv_pins == $past(drv_pins, 5) |=> bus_rdata[6:0] == $past(drv_pins))
		else $error("driver flags differ from pins");
	a_irq_masked: assert property (en_r == 4'h0 && $past(en_r) == 4'h0 |-> !irq)
		else $error("interrupt while all masked");
endmodule

bind acs_axis_status acs_axis_status_sva #(.TICK_CYC(TICK_CYC)) u_acs_axis_status_sva (
	.clk(clk),
	.nrst(nrst),
	.clk_en(clk_en),
	.bus_req(bus_req),
	.bus_rdata(bus_rdata),
	.run_current(run_current),
	.ramp_phase(ramp_phase),
	.velocity_zero(velocity_zero),
	.load_value(load_value),
	.stall_event(stall_event),
	.deviation_event(deviation_event),
	.drv_pins(drv_pins),
	.coil_current(coil_current),
	.motor_power_en(motor_power_en),
	.irq(irq)
);

//--- tb/acs_host_model.sv
// acs_host_model: host side of the register port, one-cycle strobes except rd2, which holds its read strobe for two cycles
// assumes read data stand from the cycle after the strobe until the next read
module acs_host_model
	import acs_pkg::*;
(
	input  wire logic                       clk,
	output acs_pkg::acs_bus_req_t           bus_req,
	input  wire logic [acs_pkg::DATA_W-1:0] bus_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial bus_req = '0;

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask

	// two reads with no gap, strobe held across both
	task automatic rd2(input logic [11:0] a, output logic [31:0] d0, output logic [31:0] d1);
		@(posedge clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge clk);
		#1;
		d0 = bus_rdata;
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1;
		d1 = bus_rdata;
	endtask
endmodule

//--- tb/acs_axis_status_test.sv
// acs_axis_status_test: directed scenarios for the axis status block
// assumes the checker binds itself; long counts shortened by parameters
module acs_axis_status_test;
	timeunit 1ns;
	timeprecision 100ps;
	import acs_pkg::*;
	localparam int unsigned TICK = 10;
	localparam int unsigned STILL = 16;
	logic          clk = 1'b0;
	logic          nrst = 1'b0;
	logic          clk_en = 1'b1;
	acs_bus_req_t  bus_req;
	logic [31:0]   bus_rdata;
	logic [7:0]    run_current = 8'h33;
	logic          ramp_phase = 1'b0;
	logic          velocity_zero = 1'b0;
	logic          motion_cmd = 1'b0;
	logic [9:0]    load_value = 10'h000;
	logic          stall_event = 1'b0;
	logic          deviation_event = 1'b0;
	acs_drv_pins_t drv_pins = '0;
	logic          step_pin = 1'b0;
	logic          enc_a_pin = 1'b0;
	logic          enc_b_pin = 1'b0;
	logic [7:0]    coil_current;
	logic          motor_power_en;
	logic          irq;
	logic [31:0]   rd_a;
	logic [31:0]   rd_b;
	int            err_count = 0;
	int            checks_done = 0;
	always #5 clk = ~clk;

	acs_axis_status #(.TICK_CYC(TICK), .STILL_CYC(STILL)) u_acs_axis_status (
		.clk(clk), .nrst(nrst), .clk_en(clk_en), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .run_current(run_current), .ramp_phase(ramp_phase),
		.velocity_zero(velocity_zero), .motion_cmd(motion_cmd), .load_value(load_value),
		.stall_event(stall_event), .deviation_event(deviation_event), .drv_pins(drv_pins),
		.step_pin(step_pin), .enc_a_pin(enc_a_pin), .enc_b_pin(enc_b_pin),
		.coil_current(coil_current), .motor_power_en(motor_power_en), .irq(irq));
	acs_host_model u_acs_host_model (.clk(clk), .bus_req(bus_req), .bus_rdata(bus_rdata));

	// ==========
	// shared helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		if (err_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ends just after an edge so outputs have settled
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		u_acs_host_model.rd(a, rd_a);
		check(rd_a, exp);
	endtask

	task automatic wrh(input logic [11:0] a, input logic [31:0] d);
		u_acs_host_model.wr(a, d);
	endtask

	// m: bit0 stall, bit1 deviation, bit2 motion command
	task automatic pulse(input logic [2:0] m);
		@(posedge clk);
		{motion_cmd, deviation_event, stall_event} <= m;
		@(posedge clk);
		{motion_cmd, deviation_event, stall_event} <= 3'h0;
	endtask

	task automatic quad(input logic up);
		logic [1:0] g [4];
		int n;
		g = '{2'b00, 2'b10, 2'b11, 2'b01};
		for (int k = 0; k < 4; k++) begin
			n = up ? (k + 1) % 4 : 3 - k;
			@(posedge clk);
			{enc_a_pin, enc_b_pin} <= g[n];
			wait_cyc(5);
		end
	endtask

	// ==========
	// scenarios
	task automatic t_reset;
		rdc(12'h330, 32'h0);
		rdc(12'h320, 32'h0);
		rdc(12'h3FC, 32'h0);
		rdc(12'h384, 32'h0);
		check({31'h0, motor_power_en}, 32'h1);
	endtask

	task automatic t_boost;
		@(posedge clk);
		ramp_phase <= 1'b1;
		wait_cyc(3);
		check({24'h0, coil_current}, 32'h33);
		wrh(12'h320, 32'h1FF);
		wait_cyc(2);
		check({24'h0, coil_current}, 32'hFF);
		rdc(12'h320, 32'hFF);
		@(posedge clk);
		ramp_phase <= 1'b0;
		wait_cyc(2);
		check({24'h0, coil_current}, 32'h33);
	endtask

	task automatic t_freewheel;
		wrh(12'h388, 32'h8);
		wrh(12'h330, 32'h2);
		@(posedge clk);
		velocity_zero <= 1'b1;
		wait_cyc(2 * TICK - 4);
		check({31'h0, motor_power_en}, 32'h1);
		wait_cyc(8);
		check({31'h0, motor_power_en}, 32'h0);
		check({31'h0, irq}, 32'h1);
		rdc(12'h380, 32'h8);
		wrh(12'h384, 32'h8);
		wait_cyc(2);
		check({31'h0, irq}, 32'h0);
		@(posedge clk);
		velocity_zero <= 1'b0;
		wait_cyc(3);
		check({31'h0, motor_power_en}, 32'h1);
		wrh(12'h330, 32'h0);
		@(posedge clk);
		velocity_zero <= 1'b1;
		wait_cyc(4 * TICK);
		check({31'h0, motor_power_en}, 32'h1);
		@(posedge clk);
		velocity_zero <= 1'b0;
	endtask

	task automatic t_irq;
		wrh(12'h388, 32'h1);
		pulse(3'h1);
		wait_cyc(3);
		check({31'h0, irq}, 32'h1);
		wrh(12'h384, 32'h1);
		wait_cyc(2);
		check({31'h0, irq}, 32'h0);
		wrh(12'h388, 32'h0);
		pulse(3'h1);
		wait_cyc(3);
		check({31'h0, irq}, 32'h0);
		rdc(12'h380, 32'h1);
		wrh(12'h384, 32'hF);
		pulse(3'h4);
		rdc(12'h33C, 32'h0);
	endtask

	task automatic t_ext;
		for (int c = 1; c < 4; c++) begin
			pulse(3'(c));
			wait_cyc(2);
			u_acs_host_model.rd2(12'h33C, rd_a, rd_b);
			check(rd_a, 32'(c));
			check(rd_b, 32'h0);
		end
	endtask

	task automatic t_load;
		@(posedge clk);
		load_value <= 10'h3FF;
		wrh(12'h338, 32'h0);
		rdc(12'h338, 32'h3FF);
		@(posedge clk);
		load_value <= 10'h155;
		rdc(12'h338, 32'h155);
	endtask

	task automatic t_drv;
		for (int i = 0; i < 7; i++) begin
			@(posedge clk);
			drv_pins <= acs_drv_pins_t'(7'h1 << i);
			wait_cyc(8);
			rdc(12'h340, 32'h80 | (32'h1 << i));
		end
		rdc(12'h380, 32'h7);
		@(posedge clk);
		drv_pins <= '0;
		step_pin <= 1'b1;
		wait_cyc(5);
		rdc(12'h340, 32'h0);
		wait_cyc(STILL + 4);
		rdc(12'h340, 32'h80);
		@(posedge clk);
		step_pin <= 1'b0;
	endtask

	task automatic t_enc;
		wrh(12'h344, 32'h10);
		quad(1'b1);
		rdc(12'h344, 32'h14);
		wrh(12'h348, 32'h0002_0000);
		quad(1'b0);
		rdc(12'h344, 32'hC);
		wrh(12'h344, 32'hFFFF_FFFF);
		quad(1'b1);
		rdc(12'h344, 32'h7);
		wrh(12'h348, 32'h0000_8000);
		quad(1'b1);
		rdc(12'h344, 32'h9);
	endtask

	// a frozen block takes neither the write nor the event
	task automatic t_freeze;
		@(posedge clk);
		clk_en <= 1'b0;
		wrh(12'h320, 32'h5A);
		pulse(3'h1);
		@(posedge clk);
		clk_en <= 1'b1;
		rdc(12'h320, 32'hFF);
		rdc(12'h33C, 32'h0);
	endtask

	// ==========
	// sequence and watchdog
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		wait_cyc(3);
		t_reset();
		t_boost();
		t_freewheel();
		t_irq();
		t_ext();
		t_load();
		t_drv();
		t_enc();
		t_freeze();
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		give_verdict();
	end
endmodule
